// *** hdl/dee_ctrl.sv ***
// Data EEPROM page access controller with array and register port
//
// Contract
// RULE_01 - Software writes zero to control bits 7:4
// RULE_02 - Busy bit low at reset, high while programming
// RULE_03 - Software sets unlock before writes, clears after
// RULE_04 - Page field frozen while load is set
// RULE_05 - Data writes under load fill page buffer
// RULE_06 - Each page byte loaded once per sequence
// RULE_07 - Clearing load starts programming, busy follows
// RULE_08 - No new access until busy clears
// RULE_09 - Read bit self-clears after fetching the byte
// RULE_10 - Data register holds last fetched byte
// RULE_11 - Address bits 6:3 page, 2:0 byte
// RULE_12 - Avoid programming while transmitter is on
// RULE_13 - Address at 0x1E, control at 0x1C
// RULE_14 - Busy self-clears; read data ready next cycle
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
// Write sequence at the register port: unlock, address, load,
// data bytes, then load cleared while unlock stays set.
// Clearing load starts a short start delay, then the programming timer.
// Busy covers both; the array takes the buffered bytes on the last cycle.
// Page field is write-locked from load set until busy falls, so a late
// address write cannot move the page that is being programmed.
// Load and read-bit writes are refused while busy; unlock always writes.
// Array contents have no reset: a byte never written reads as unknown.
// Status collects write done, read done and locked data writes;
// each bit is sticky, cleared by writing a one, and a new event wins.
// The interrupt is high while any unmasked status bit is set.
// Timing counts assume the timer runs on every clock edge.
module dee_ctrl #(
  parameter int WRITE_CYCLES = dee_pkg::WRITE_CYC  // Programming time in clocks
) (
  input  wire logic       ref_clk,         // System clock, 50 MHz
  input  wire logic       rst_n,           // Synchronous reset, active low
  input  wire logic [7:0] reg_addr,        // Register address
  input  wire logic [7:0] reg_wdata,       // Write data
  input  wire logic       reg_wr,          // Write strobe
  input  wire logic       reg_rd,          // Read strobe
  output logic      [7:0] reg_rdata,       // Read data, cycle after strobe
  input  wire logic       transmitter_on,  // Radio transmitter enabled
  output logic            irq              // Level interrupt
);

  // Timer wide enough for the start delay and the programming time
  localparam int CW = $clog2(WRITE_CYCLES + dee_pkg::START_DLY + 1);

  // Storage array and page buffer
  logic [7:0]    mem_r [dee_pkg::MEM_BYTES];       // EEPROM array
  logic [7:0]    pbuf_r [dee_pkg::PAGE_BYTES];     // Page buffer
  logic [7:0]    pvld_r;                           // Buffered byte valid
  // Registers
  logic [7:0]    data_r;                           // eeprom_data_byte
  logic [6:0]    addr_r;                           // eeprom_page_byte_address
  logic          unlock_r;                         // Unlock bit
  logic          load_r;                           // Load bit
  logic          read_r;                           // Read bit
  logic [2:0]    stat_r;                           // Sticky events
  logic [2:0]    mask_r;                           // Interrupt mask
  logic [CW-1:0] cnt_r;                            // Programming timer
  logic [CW-1:0] cnt_nxt;                          // Timer next value
  dee_pkg::dee_state_t st_r;                       // Controller state
  dee_pkg::dee_state_t st_nxt;                     // Next state
  logic          busy;                             // Programming in progress
  logic          wr_ctl;                           // Control write
  logic          wr_dat;                           // Data write
  logic          wr_adr;                           // Address write
  logic          load_fall;                        // Load cleared with unlock
  logic          prog_done;                        // Programming complete
  logic [2:0]    ev;                               // Event pulses
  logic [2:0]    stat_nxt;                         // Status next value
  logic [2:0]    mask_nxt;                         // Mask next value
  logic          wr_sts;                           // Status write
  logic          wr_msk;                           // Mask write
  logic          page_lock;                        // Page field write-locked

  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write decodes, one per register
  assign wr_ctl = reg_wr && hit(reg_addr, dee_pkg::OFS_CTRL);
  assign wr_dat = reg_wr && hit(reg_addr, dee_pkg::OFS_DATA);
  assign wr_adr = reg_wr && hit(reg_addr, dee_pkg::OFS_ADDR);
  assign wr_sts = reg_wr && hit(reg_addr, dee_pkg::OFS_STATUS);
  assign wr_msk = reg_wr && hit(reg_addr, dee_pkg::OFS_MASK);

  // Busy covers the start delay and the programming time
  // RULE_02 busy from state
  assign busy = (st_r != dee_pkg::ST_IDLE);

  // Page stays put from load set until the array write is over
  assign page_lock = load_r || busy;

  // Needs unlock both held and in the written value
  // RULE_07 start on load clear
  assign load_fall = wr_ctl && load_r && !reg_wdata[dee_pkg::CTL_LOAD]
                     && reg_wdata[dee_pkg::CTL_UNLOCK] && unlock_r;

  // Last programming cycle; the array takes the page here
  assign prog_done = (st_r == dee_pkg::ST_PROG) && (cnt_r == '0);

  // Next-state logic of the programming sequencer
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      dee_pkg::ST_IDLE: begin
        // Programming waits a short start delay
        if (load_fall) begin
          st_nxt  = dee_pkg::ST_START;
          cnt_nxt = CW'(dee_pkg::START_DLY - 1);
        end
      end
      dee_pkg::ST_START: begin
        // Count down the start delay
        if (cnt_r == '0) begin
          st_nxt  = dee_pkg::ST_PROG;
          cnt_nxt = CW'(WRITE_CYCLES - 1);
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      dee_pkg::ST_PROG: begin
        // RULE_14 busy self-clears
        if (cnt_r == '0) begin
          st_nxt = dee_pkg::ST_IDLE;
        end else begin
          // Programming time still running
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        // Stray state code falls back to idle
        st_nxt  = dee_pkg::ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  // State and timer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Sequencer idle, timer cleared
      st_r  <= dee_pkg::ST_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Control bits; read bit self-clears one cycle after set
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Unlock, load and read all clear
      unlock_r <= 1'b0;
      load_r   <= 1'b0;
      read_r   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        // Unlock follows every control write
        unlock_r <= reg_wdata[dee_pkg::CTL_UNLOCK];
        // Load only takes effect when idle
        if (!busy) begin
          load_r <= reg_wdata[dee_pkg::CTL_LOAD];
        end
      end
      // RULE_09 read bit self-clears
      if (read_r) begin
        read_r <= 1'b0;
      end else if (wr_ctl && reg_wdata[dee_pkg::CTL_READ] && !busy) begin
        // One-cycle fetch, refused while busy
        read_r <= 1'b1;
      end
    end
  end

  // Address register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Page 0, byte 0
      addr_r <= '0;
    end else if (wr_adr) begin
      // RULE_11 byte field always writable
      addr_r[dee_pkg::ADR_BYTE_HI:0] <= reg_wdata[dee_pkg::ADR_BYTE_HI:0];
      // Freezing through busy keeps the page of the write in flight
      // RULE_04 page frozen under load
      if (!page_lock) begin
        addr_r[dee_pkg::ADR_PAGE_HI:dee_pkg::ADR_PAGE_LO] <=
          reg_wdata[dee_pkg::ADR_PAGE_HI:dee_pkg::ADR_PAGE_LO];
      end
    end
  end

  // Data register: software writes or array fetch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Reset value of the data byte
      data_r <= dee_pkg::RST_BYTE;
    end else if (read_r) begin
      // A fetch beats a software write in the same cycle
      // RULE_10 fetched byte replaces data
      data_r <= mem_r[addr_r];
    end else if (wr_dat) begin
      // Software byte, also the buffer source
      data_r <= reg_wdata;
    end
  end

  // Page buffer fill and valid tracking
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Empty buffer, no byte pending
      pvld_r <= '0;
      for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
        pbuf_r[i] <= dee_pkg::RST_BYTE;
      end
    end else if (prog_done) begin
      // Page is in the array, start over
      pvld_r <= '0;
    end else if (wr_dat && load_r && unlock_r) begin
      // RULE_05 buffer byte at offset
      pbuf_r[addr_r[dee_pkg::ADR_BYTE_HI:0]] <= reg_wdata;
      pvld_r[addr_r[dee_pkg::ADR_BYTE_HI:0]] <= 1'b1;
    end
  end

  // Array update at end of programming; array content is not reset
  always_ff @(posedge ref_clk) begin
    if (prog_done) begin
      for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
        // Bytes not loaded keep their old content
        if (pvld_r[i]) begin
          mem_r[{addr_r[dee_pkg::ADR_PAGE_HI:dee_pkg::ADR_PAGE_LO], 3'(i)}] <= pbuf_r[i];
        end
      end
    end
  end

  // Event pulses, one cycle each
  // Write done on the last programming cycle
  assign ev[dee_pkg::IRQ_WDONE] = prog_done;
  // Read done while the fetch lands
  assign ev[dee_pkg::IRQ_RDONE] = read_r;
  // Data write under load with unlock clear is flagged, not buffered
  assign ev[dee_pkg::IRQ_BLOCK] = wr_dat && load_r && !unlock_r;

  // Status and mask next values; a new event beats a clear in one cycle
  always_comb begin
    stat_nxt = stat_r | ev;
    mask_nxt = mask_r;
    if (wr_sts) begin
      // Write one to clear, then set by this cycle's events
      stat_nxt = (stat_r & ~reg_wdata[2:0]) | ev;
    end
    if (wr_msk) begin
      // Mask bits beyond the event count are dropped
      mask_nxt = reg_wdata[2:0];
    end
  end

  // Sticky status and mask registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Interrupt level follows the unmasked status with no lag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;  // Quiet through reset
    end else begin
      irq <= |(stat_nxt & mask_nxt);
    end
  end

  // RULE_13 read mux, one cycle latency
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      // Reserved bits read as zero
      case (reg_addr)
        dee_pkg::OFS_CTRL:   reg_rdata <= {4'h0, busy, unlock_r, load_r, read_r};
        dee_pkg::OFS_DATA:   reg_rdata <= data_r;
        dee_pkg::OFS_ADDR:   reg_rdata <= {1'b0, addr_r};
        // Transmitter state shows beside the events
        dee_pkg::OFS_STATUS: reg_rdata <= {4'h0, transmitter_on, stat_r};
        dee_pkg::OFS_MASK:   reg_rdata <= {5'h00, mask_r};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      // Data lines rest at zero between reads
      reg_rdata <= '0;
    end
  end

endmodule

// *** pkg/dee_pkg.sv ***
// Constants for the data EEPROM page access controller
package dee_pkg;
  // Register offsets in I/O space
  localparam logic [7:0] OFS_CTRL   = 8'h1C;  // eeprom_access_control
  localparam logic [7:0] OFS_DATA   = 8'h1D;  // eeprom_data_byte
  localparam logic [7:0] OFS_ADDR   = 8'h1E;  // eeprom_page_byte_address
  localparam logic [7:0] OFS_STATUS = 8'h24;  // Interrupt status
  localparam logic [7:0] OFS_MASK   = 8'h25;  // Interrupt mask
  // Control field positions
  localparam int CTL_READ   = 0;
  localparam int CTL_LOAD   = 1;
  localparam int CTL_UNLOCK = 2;
  localparam int CTL_BUSY   = 3;
  // Address field positions
  localparam int ADR_PAGE_HI = 6;
  localparam int ADR_PAGE_LO = 3;
  localparam int ADR_BYTE_HI = 2;
  // Interrupt status bits
  localparam int IRQ_WDONE = 0;  // Page write finished
  localparam int IRQ_RDONE = 1;  // Read finished
  localparam int IRQ_BLOCK = 2;  // Write refused, unlock clear
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Geometry
  localparam int PAGE_BYTES = 8;
  localparam int MEM_BYTES  = 128;
  // Timing
  localparam int CLK_HZ      = 50000000;
  localparam int WRITE_MS    = 4;
  localparam int WRITE_CYC   = CLK_HZ / 1000 * WRITE_MS;
  localparam int START_DLY   = 4;  // Cycles from load clear to programming start
  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_PROG  = 2'b10
  } dee_state_t;
endpackage

// *** tb/dee_chk.sv ***
// Port assertions for the data EEPROM access controller
`timescale 1ns/10ps
module dee_chk #(
  parameter int WRITE_CYCLES = 20  // Programming clocks
) (
  input wire logic       ref_clk,         // Clock
  input wire logic       rst_n,           // Reset
  input wire logic [7:0] reg_addr,        // Address
  input wire logic [7:0] reg_wdata,       // Write data
  input wire logic       reg_wr,          // Write strobe
  input wire logic       reg_rd,          // Read strobe
  input wire logic [7:0] reg_rdata,       // Read data
  input wire logic       transmitter_on,  // Radio on
  input wire logic       irq              // Interrupt
);
  localparam logic [7:0] CT = dee_pkg::OFS_CTRL;         // Control
  localparam logic [7:0] AD = dee_pkg::OFS_ADDR;         // Address
  localparam int N = WRITE_CYCLES + dee_pkg::START_DLY;  // Busy length
  logic [6:0] adr_r;  // Shadow address
  logic       ld_r;   // Shadow load
  logic       unl_r;  // Shadow unlock
  logic [7:0] msk_r;  // Shadow mask
  int         cnt_r;  // Busy countdown
  logic       cw;     // Control write
  assign cw = reg_wr && reg_addr == CT;
  // Follow what software has set up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      adr_r <= '0;
      ld_r  <= 1'b0;
      unl_r <= 1'b0;
      msk_r <= '0;
      cnt_r <= 0;
    end else begin
      if (reg_wr && reg_addr == AD)
        adr_r <= {(ld_r || cnt_r != 0) ? adr_r[6:3] : reg_wdata[6:3], reg_wdata[2:0]};
      if (cw && cnt_r == 0)
        ld_r <= reg_wdata[1];
      if (cw)
        unl_r <= reg_wdata[2];
      if (reg_wr && reg_addr == dee_pkg::OFS_MASK)
        msk_r <= reg_wdata;
      if (cw && ld_r && unl_r && reg_wdata[2:1] == 2'b10 && cnt_r == 0)
        cnt_r <= N;
      else if (cnt_r != 0)
        cnt_r <= cnt_r - 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h1F |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_page_frozen: assert property (
    reg_rd && reg_addr == AD |=> reg_rdata[6:0] == $past(adr_r)) else $error("address wrong");
  a_data_back: assert property (
    reg_wr && reg_addr == dee_pkg::OFS_DATA ##1 reg_rd && reg_addr == dee_pkg::OFS_DATA
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("data byte not kept");
  a_read_selfclr: assert property (
    reg_rd && reg_addr == CT && $past(cw && reg_wdata[0], 2) |=> !reg_rdata[0])
    else $error("read bit still set");
  a_busy_high: assert property (
    reg_rd && reg_addr == CT && cnt_r > 2 && cnt_r < N - 1 |=> reg_rdata[3])
    else $error("busy low while programming");
  a_busy_low: assert property (
    reg_rd && reg_addr == CT && cnt_r == 0 && $past(cnt_r, 3) == 0 |=> !reg_rdata[3])
    else $error("busy high while idle");
  a_irq_masked: assert property (
    msk_r == 8'h00 && $past(msk_r) == 8'h00 |-> !irq) else $error("interrupt while masked");
  c_prog: cover property (cnt_r == N);
  c_frozen: cover property (reg_rd && reg_addr == AD && ld_r);
  c_irq: cover property (irq);
  c_locked: cover property (reg_wr && reg_addr == dee_pkg::OFS_DATA && ld_r && !unl_r);
endmodule

// *** tb/dee_ctrl_bench.sv ***
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module dee_ctrl_bench;
  localparam int WC = 20;  // Short programming time
  localparam logic [7:0] CT = dee_pkg::OFS_CTRL;    // Control
  localparam logic [7:0] DA = dee_pkg::OFS_DATA;    // Data
  localparam logic [7:0] AD = dee_pkg::OFS_ADDR;    // Address
  localparam logic [7:0] ST = dee_pkg::OFS_STATUS;  // Status
  logic       ref_clk = 1'b0;         // Clock
  logic       rst_n = 1'b0;           // Reset
  logic [7:0] reg_addr = 8'h00;       // Address
  logic [7:0] reg_wdata = 8'h00;      // Write data
  logic       reg_wr = 1'b0;          // Write strobe
  logic       reg_rd = 1'b0;          // Read strobe
  logic       transmitter_on = 1'b0;  // Radio on
  logic [7:0] reg_rdata;              // Read data
  logic       irq;                    // Interrupt
  int         failures = 0;           // Mismatches
  int         n_checks = 0;           // Comparisons
  int         cyc = 0;                // Cycles run
  dee_ctrl #(.WRITE_CYCLES(WC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transmitter_on(transmitter_on), .irq(irq));
  // Clock
  always #10 ref_clk = ~ref_clk;
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      summarize();
    end
  end
  // Write strobe, left up for back-to-back use
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask
  // Idle cycles, strobes low
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
  // Read and compare the bits under m
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("read data", e & m, reg_rdata & m)
  endtask
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Test sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h1F, 8'hFF);
    rc(CT, 8'h00, 8'hFF);
    rc(AD, 8'h00, 8'h7F);
    rc(8'h1F, 8'h00, 8'hFF);
    wr(DA, 8'h5A);
    rc(DA, 8'h5A, 8'hFF);
    $display("register test done");
    wr(CT, 8'h04);
    wr(AD, 8'h2B);
    wr(CT, 8'h06);
    wr(DA, 8'hA5);
    wr(AD, 8'h4C);
    rc(AD, 8'h2C, 8'h7F);
    wr(DA, 8'h3C);
    wr(CT, 8'h04);
    idle(8);
    rc(CT, 8'h08, 8'h08);
    idle(WC);
    rc(CT, 8'h04, 8'h0F);
    rc(ST, 8'h01, 8'h01);
    `CHK("irq", 1'b0, irq)
    wr(dee_pkg::OFS_MASK, 8'h01);
    idle(2);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(ST, 8'h01);
    idle(2);
    #1;
    `CHK("irq", 1'b0, irq)
    $display("page write test done");
    wr(CT, 8'h00);
    wr(AD, 8'h2B);
    wr(CT, 8'h01);
    idle(1);
    rc(CT, 8'h00, 8'h01);
    rc(DA, 8'hA5, 8'hFF);
    wr(AD, 8'h2C);
    wr(CT, 8'h01);
    idle(2);
    transmitter_on <= 1'b1;
    rc(DA, 8'h3C, 8'hFF);
    rc(ST, 8'h0A, 8'h0B);
    `CHK("irq", 1'b0, irq)
    $display("read test done");
    wr(CT, 8'h02);
    wr(DA, 8'h77);
    wr(CT, 8'h00);
    idle(1);
    rc(CT, 8'h00, 8'h0F);
    rc(ST, 8'h0E, 8'h0F);
    wr(dee_pkg::OFS_MASK, 8'h04);
    idle(2);
    #1;
    `CHK("irq", 1'b1, irq)
    $display("lock test done");
    summarize();
  end
endmodule
bind dee_ctrl dee_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .transmitter_on(transmitter_on), .irq(irq));
